// File: test/lsq_host_model.sv
// host model: issues register writes and reads to the sequencer
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
module lsq_host_model (
  input wire logic clk_sys_i,
  input wire logic [31:0] rdata_i,
  output logic [6:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial
  begin
    addr_o = 7'h7f;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // released lines show inverted values so stale data is never reused
  task automatic bus_wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic bus_rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule

// File: test/lsq_seq_asserts.sv
// port checker of the output list sequencer
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module lsq_seq_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [6:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [15:0] level_o,
  input wire logic running_o,
  input wire logic error_o
);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_mode(logic [1:0] m);
    wr_i && addr_i == lsq_pkg::A_MODE && wdata_i[1:0] == m;
  endsequence

  sequence s_list_acc;
    running_o && (wr_i || rd_i) && addr_i <= lsq_pkg::A_SKIP;
  endsequence

  sequence s_rd(logic [6:0] a);
    rd_i && addr_i == a;
  endsequence

  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside a read answer");
  a_run_start: assert property (
    s_mode(lsq_pkg::MODE_LIST) ##0 !running_o |=> running_o || error_o)
    else $error("run request neither started nor refused");
  a_fixed_stop: assert property (
    s_mode(lsq_pkg::MODE_FIXED) |=> !running_o)
    else $error("fixed mode left the list running");
  a_busy_reject: assert property (
    s_list_acc |=> error_o && rdata_o == 32'h0)
    else $error("list access while running not refused");
  a_err_sticky: assert property (
    error_o && !(rd_i && addr_i == lsq_pkg::A_ERROR) |=> error_o)
    else $error("error flag dropped without a read");
  a_err_read: assert property (
    s_rd(lsq_pkg::A_ERROR) ##0 error_o |=> rdata_o[16])
    else $error("pending bit missing from error read");
  a_qstart_max: assert property (
    s_rd(lsq_pkg::A_QSTART) |=> rdata_o <= 32'h0000_03e9)
    else $error("readback start above last location");
  a_order_bit: assert property (
    s_rd(lsq_pkg::A_ORDER_SEL) |=> rdata_o[31:1] == 31'h0)
    else $error("order select read has extra bits");
endmodule

bind lsq_sequencer lsq_seq_asserts chk_u (
  .clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .level_o(level_o),
  .running_o(running_o),
  .error_o(error_o)
);

// File: test/testbench.sv
// self-checking bench of the output list sequencer
// assumes the host model drives every register port input
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  typedef struct packed {logic w; logic [6:0] a; logic [31:0] d;} lsq_row_t;
  logic clk_sys_i, nrst_i, wr_i, rd_i, running_o, error_o;
  logic [6:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rd_v;
  logic [15:0] level_o, lv;
  int failures = 0;
  int check_count = 0;
  int n;
  logic run_q;
  logic [15:0] lvl [4] = '{16'h000a, 16'h0014, 16'h001e, 16'h0028};
  int dw [4] = '{2, 3, 1, 2};
  lsq_row_t rows [$] = '{
    '{1'h0, 7'h00, 32'h0}, '{1'h0, 7'h04, 32'h0}, '{1'h0, 7'h08, 32'h0},
    '{1'h0, 7'h28, 32'h1}, '{1'h0, 7'h2c, 32'h0}, '{1'h0, 7'h3c, 32'h1},
    '{1'h0, 7'h38, 32'h0}, '{1'h0, 7'h40, 32'h0}, '{1'h0, 7'h7c, 32'h0},
    '{1'h1, 7'h00, 32'h1}, '{1'h0, 7'h00, 32'h1},
    '{1'h1, 7'h0c, 32'h3}, '{1'h1, 7'h0c, 32'h2}, '{1'h1, 7'h0c, 32'h3},
    '{1'h1, 7'h0c, 32'h0}, '{1'h1, 7'h14, 32'ha}, '{1'h1, 7'h14, 32'h14},
    '{1'h1, 7'h14, 32'h1e}, '{1'h1, 7'h14, 32'h28}, '{1'h1, 7'h1c, 32'h2},
    '{1'h1, 7'h1c, 32'h3}, '{1'h1, 7'h1c, 32'h1}, '{1'h1, 7'h1c, 32'h2},
    '{1'h0, 7'h10, 32'h4}, '{1'h0, 7'h18, 32'h4}, '{1'h0, 7'h20, 32'h4},
    '{1'h1, 7'h0c, 32'h200}, '{1'h0, 7'h40, 32'h1ff22},
    '{1'h0, 7'h10, 32'h4}, '{1'h1, 7'h08, 32'h1}, '{1'h0, 7'h0c, 32'h2},
    '{1'h0, 7'h14, 32'h1e}, '{1'h0, 7'h1c, 32'h2}, '{1'h0, 7'h1c, 32'h0},
    '{1'h0, 7'h08, 32'h1}, '{1'h1, 7'h08, 32'h3ea}, '{1'h0, 7'h08, 32'h1},
    '{1'h0, 7'h40, 32'h1ff22}, '{1'h0, 7'h40, 32'hff22}};

  lsq_sequencer dut_u (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .level_o(level_o),
    .running_o(running_o),
    .error_o(error_o)
  );

  lsq_host_model host_u (
    .clk_sys_i(clk_sys_i),
    .rdata_i(rdata_o),
    .addr_o(addr_i),
    .wdata_o(wdata_i),
    .wr_o(wr_i),
    .rd_o(rd_i)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // counts how long each step holds its level
  task automatic watch(input int locs[$], input bit stop);
    n = 0;
    while (running_o !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    tick(1);
    // running drops one cycle before the last level ends
    run_q = 1'b1;
    foreach (locs[k])
    begin
      n = 0;
      while (level_o === lvl[locs[k]] && n < 20 &&
             (running_o === 1'b1 || run_q === 1'b1 || !stop))
      begin
        run_q = running_o;
        n++;
        tick(1);
      end
      `CHK(n, dw[locs[k]]);
    end
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #2000000;
    failures++;
    results();
  end

  initial
  begin
    nrst_i = 1'b0;
    tick(16);
    nrst_i <= 1'b1;
    foreach (rows[i])
      if (rows[i].w)
        host_u.bus_wr(rows[i].a, rows[i].d);
      else
      begin
        host_u.bus_rd(rows[i].a, rd_v);
        `CHK(rd_v, rows[i].d);
      end
    host_u.bus_wr(7'h30, 32'h1);
    watch('{3, 2, 3, 0}, 1'b1);
    `CHK(level_o, lvl[0]);
    host_u.bus_wr(7'h00, 32'h0);
    host_u.bus_wr(7'h04, 32'h1);
    host_u.bus_wr(7'h30, 32'h1);
    watch('{3, 2, 1, 0}, 1'b1);
    host_u.bus_wr(7'h04, 32'h0);
    host_u.bus_wr(7'h28, 32'h0);
    host_u.bus_wr(7'h2c, 32'h2);
    host_u.bus_wr(7'h30, 32'h1);
    watch('{0, 1, 2, 3, 2, 3, 2}, 1'b0);
    `CHK(running_o, 1'b1);
    host_u.bus_rd(7'h00, rd_v);
    `CHK(rd_v, 32'h0);
    host_u.bus_rd(7'h40, rd_v);
    `CHK(rd_v, 32'h1ff23);
    host_u.bus_wr(7'h30, 32'h0);
    tick(2);
    `CHK(running_o, 1'b0);
    lv = level_o;
    tick(8);
    `CHK(level_o, lv);
    host_u.bus_wr(7'h24, 32'h0);
    host_u.bus_wr(7'h14, 32'h5);
    host_u.bus_wr(7'h30, 32'h1);
    tick(4);
    `CHK(running_o, 1'b0);
    `CHK(error_o, 1'b1);
    host_u.bus_rd(7'h40, rd_v);
    `CHK(rd_v, 32'h1ff23);
    `CHK(error_o, 1'b0);
    host_u.bus_wr(7'h38, 32'hfffc);
    tick(2);
    `CHK(level_o, 16'hfffc);
    host_u.bus_wr(7'h34, 32'h5);
    host_u.bus_wr(7'h30, 32'h2);
    host_u.bus_wr(7'h38, 32'h3);
    n = 0;
    while (level_o !== 16'h0003 && n < 10)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (level_o === 16'h0003 && n < 20)
    begin
      n++;
      tick(1);
    end
    `CHK(n, 5);
    `CHK(level_o, 16'hfffc);
    host_u.bus_wr(7'h3c, 32'h4);
    tick(2);
    `CHK(level_o, 16'hffff);
    host_u.bus_wr(7'h10, 32'h0);
    for (int i = 0; i < 512; i++)
      host_u.bus_wr(7'h0c, 32'(511 - i));
    host_u.bus_rd(7'h10, rd_v);
    `CHK(rd_v, 32'h200);
    host_u.bus_wr(7'h0c, 32'h0);
    host_u.bus_rd(7'h40, rd_v);
    `CHK(rd_v, 32'h1ff22);
    host_u.bus_wr(7'h08, 32'h0);
    for (int i = 0; i < 17; i++)
    begin
      host_u.bus_rd(7'h0c, rd_v);
      `CHK(rd_v, (i < 16) ? 32'(511 - i) : 32'h0);
    end
    results();
  end
endmodule

// File: verilog/lsq_pkg.sv
// constants, register map and state type of the output list sequencer
// assumes a single 40 MHz clock domain and a plain register port
package lsq_pkg;

  // ----------------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------------
  localparam int LOC_W = 10;
  localparam int ORD_W = 9;
  localparam int LVL_W = 16;
  localparam int DW_W = 24;
  localparam int CNT_W = 16;
  localparam int RB_W = 5;
  localparam int ADDR_W = 7;
  localparam int LIST_DEPTH = 1002;
  localparam int ORD_DEPTH = 512;

  // ----------------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------------
  localparam logic [LOC_W-1:0] LIST_FULL = 10'h3ea;
  localparam logic [LOC_W-1:0] LOC_LAST = 10'h3e9;
  localparam logic [LOC_W-1:0] ORD_FULL = 10'h200;
  localparam logic [31:0] ORD_VAL_MAX = 32'h0000_01ff;
  localparam logic [RB_W-1:0] RB_MAX = 5'h10;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_ORDER_SEL = 7'h00;
  localparam logic [ADDR_W-1:0] A_DIR = 7'h04;
  localparam logic [ADDR_W-1:0] A_QSTART = 7'h08;
  localparam logic [ADDR_W-1:0] A_ORDER_DATA = 7'h0c;
  localparam logic [ADDR_W-1:0] A_ORDER_PTR = 7'h10;
  localparam logic [ADDR_W-1:0] A_LEVEL_DATA = 7'h14;
  localparam logic [ADDR_W-1:0] A_LEVEL_PTR = 7'h18;
  localparam logic [ADDR_W-1:0] A_DWELL_DATA = 7'h1c;
  localparam logic [ADDR_W-1:0] A_DWELL_PTR = 7'h20;
  localparam logic [ADDR_W-1:0] A_CLEAR = 7'h24;
  localparam logic [ADDR_W-1:0] A_COUNT = 7'h28;
  localparam logic [ADDR_W-1:0] A_SKIP = 7'h2c;
  localparam logic [ADDR_W-1:0] A_MODE = 7'h30;
  localparam logic [ADDR_W-1:0] A_PULSE_DUR = 7'h34;
  localparam logic [ADDR_W-1:0] A_LEVEL = 7'h38;
  localparam logic [ADDR_W-1:0] A_RANGE = 7'h3c;
  localparam logic [ADDR_W-1:0] A_ERROR = 7'h40;

  // ----------------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_FIXED = 2'h0;
  localparam logic [1:0] MODE_LIST = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [3:0] RANGE_FULL = 4'h1;
  localparam logic [3:0] RANGE_QUARTER = 4'h4;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CONFLICT = 16'hff23;
  localparam logic [15:0] ERR_RANGE = 16'hff22;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_HOLD = 2'b10,
    ST_PULSE = 2'b11
  } lsq_state_t;

endpackage

// File: verilog/lsq_sequencer.sv
// output list sequencer: tables, order select, readback, run and pulse
// assumes register port on clk_sys_i, one-cycle strobes, never both
//
// What this block does
// R1: order select holds default or user order
// R2: default order steps locations up or down
// R3: user order follows order table, honours direction
// R4: order select is readable
// R5: readback start pointer accepts 0 to 1001
// R6: start pointer serves all readbacks, readable
// R7: order writes fill cells from 0, max 512
// R8: order cells may repeat any data point from 0 to 511
// R9: readback returns at most 16 consecutive cells
// R10: unequal level and dwell counts refuse run, -221
// R11: list access while running rejected with -221
// R12: repeat count zero repeats until stopped
// R13: fixed mode stops list, keeps last level
// R14: dwell pointer counts entries, writes append
// R15: each step holds its level for its dwell
// R16: armed pulse drives next level, then restores
// R17: range 4 scales output to one quarter
// R18: level writes append from 0, max 1002
// R19: skip steps run on first pass only
// R20: bad order writes rejected, table unchanged
// R21: host balances lists and stops before commands
`timescale 1ns/1ps
module lsq_sequencer (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [6:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [15:0] level_o,
  output logic running_o,
  output logic error_o
);

  localparam int LW = lsq_pkg::LOC_W;
  localparam int OW = lsq_pkg::ORD_W;
  localparam int VW = lsq_pkg::LVL_W;
  localparam int DW = lsq_pkg::DW_W;
  localparam int CW = lsq_pkg::CNT_W;
  localparam int RW = lsq_pkg::RB_W;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  lsq_pkg::lsq_state_t state_reg, state_next;
  logic order_sel_reg, order_sel_next;
  logic dir_reg, dir_next;
  logic [LW-1:0] qstart_reg, qstart_next;
  logic [RW-1:0] rb_idx_reg, rb_idx_next;
  logic [LW-1:0] ord_cnt_reg, ord_cnt_next;
  logic [LW-1:0] lvl_cnt_reg, lvl_cnt_next;
  logic [LW-1:0] dw_cnt_reg, dw_cnt_next;
  logic [CW-1:0] count_reg, count_next;
  logic [LW-1:0] skip_reg, skip_next;
  logic [LW-1:0] pos_reg, pos_next;
  logic [CW-1:0] pass_reg, pass_next;
  logic [DW-1:0] timer_reg, timer_next;
  logic [DW-1:0] pulse_dur_reg, pulse_dur_next;
  logic pulse_armed_reg, pulse_armed_next;
  logic [VW-1:0] level_reg, level_next;
  logic [VW-1:0] out_reg, out_next;
  logic [VW-1:0] restore_reg, restore_next;
  logic [3:0] range_reg, range_next;
  logic [15:0] err_code_reg, err_code_next;
  logic err_flag_reg, err_flag_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [VW-1:0] level_o_reg, level_o_next;

  // ----------------------------------------------------------------------
  // tables
  // ----------------------------------------------------------------------
  logic ord_we, lvl_we, dw_we;
  logic [LW-1:0] n_steps, idx, loc, rb_addr, pos_inc, restart_pos;
  logic [OW-1:0] ord_rd_a, ord_rd_b;
  logic [VW-1:0] lvl_rd_a, lvl_rd_b;
  logic [DW-1:0] dw_rd_a, dw_rd_b;

  lsq_table #(.WIDTH(OW), .DEPTH(lsq_pkg::ORD_DEPTH), .AW(OW)) u_order (
    .clk_sys_i(clk_sys_i),
    .we_i(ord_we),
    .waddr_i(ord_cnt_reg[OW-1:0]),
    .wdata_i(wdata_i[OW-1:0]),
    .raddr_a_i(idx[OW-1:0]),
    .rdata_a_o(ord_rd_a),
    .raddr_b_i(rb_addr[OW-1:0]),
    .rdata_b_o(ord_rd_b)
  );

  lsq_table #(.WIDTH(VW), .DEPTH(lsq_pkg::LIST_DEPTH), .AW(LW)) u_level (
    .clk_sys_i(clk_sys_i),
    .we_i(lvl_we),
    .waddr_i(lvl_cnt_reg),
    .wdata_i(wdata_i[VW-1:0]),
    .raddr_a_i(loc),
    .rdata_a_o(lvl_rd_a),
    .raddr_b_i(rb_addr),
    .rdata_b_o(lvl_rd_b)
  );

  lsq_table #(.WIDTH(DW), .DEPTH(lsq_pkg::LIST_DEPTH), .AW(LW)) u_dwell (
    .clk_sys_i(clk_sys_i),
    .we_i(dw_we),
    .waddr_i(dw_cnt_reg),
    .wdata_i(wdata_i[DW-1:0]),
    .raddr_a_i(loc),
    .rdata_a_o(dw_rd_a),
    .raddr_b_i(rb_addr),
    .rdata_b_o(dw_rd_b)
  );

  // ----------------------------------------------------------------------
  // step addressing
  // ----------------------------------------------------------------------
  logic running, list_acc, reject, last_step, pass_done, rb_ok;

  assign running = (state_reg == lsq_pkg::ST_LOAD) ||
                   (state_reg == lsq_pkg::ST_HOLD);
  assign n_steps = order_sel_reg ? ord_cnt_reg : lvl_cnt_reg; // R1
  assign idx = dir_reg ? LW'(n_steps - pos_reg - 10'h001) : pos_reg; // R2
  assign loc = order_sel_reg ? LW'(ord_rd_a) : idx; // R3 R8
  assign pos_inc = LW'(pos_reg + 10'h001);
  assign last_step = (pos_inc >= n_steps);
  assign pass_done = (count_reg != '0) && (pass_reg == count_reg); // R12
  assign restart_pos = (skip_reg < n_steps) ? skip_reg : '0; // R19
  assign rb_addr = LW'(qstart_reg + LW'(rb_idx_reg)); // R6
  assign rb_ok = (rb_idx_reg < lsq_pkg::RB_MAX); // R9
  assign list_acc = (addr_i <= lsq_pkg::A_SKIP);
  assign reject = running && list_acc && (wr_i || rd_i); // R11

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic err_set;
    logic [15:0] err_val;
    logic advance;
    err_set = 1'b0;
    err_val = lsq_pkg::ERR_NONE;
    advance = 1'b0;
    state_next = state_reg;
    order_sel_next = order_sel_reg;
    dir_next = dir_reg;
    qstart_next = qstart_reg;
    rb_idx_next = rb_idx_reg;
    ord_cnt_next = ord_cnt_reg;
    lvl_cnt_next = lvl_cnt_reg;
    dw_cnt_next = dw_cnt_reg;
    count_next = count_reg;
    skip_next = skip_reg;
    pos_next = pos_reg;
    pass_next = pass_reg;
    timer_next = timer_reg;
    pulse_dur_next = pulse_dur_reg;
    pulse_armed_next = pulse_armed_reg;
    level_next = level_reg;
    out_next = out_reg;
    restore_next = restore_reg;
    range_next = range_reg;
    rdata_next = '0;
    ord_we = 1'b0;
    lvl_we = 1'b0;
    dw_we = 1'b0;

    // sequencing
    case (state_reg)
      lsq_pkg::ST_LOAD:
      begin
        out_next = lvl_rd_a; // R15
        level_next = lvl_rd_a; // R13
        if (dw_rd_a > DW'(1))
        begin
          timer_next = DW'(dw_rd_a - 24'h000001); // R15
          state_next = lsq_pkg::ST_HOLD;
        end
        else
        begin
          advance = 1'b1;
        end
      end
      lsq_pkg::ST_HOLD:
      begin
        if (timer_reg <= DW'(1))
        begin
          advance = 1'b1;
        end
        else
        begin
          timer_next = DW'(timer_reg - 24'h000001);
        end
      end
      lsq_pkg::ST_PULSE:
      begin
        if (timer_reg <= DW'(1))
        begin
          out_next = restore_reg; // R16
          state_next = lsq_pkg::ST_IDLE;
        end
        else
        begin
          timer_next = DW'(timer_reg - 24'h000001);
        end
      end
      default:
      begin
        state_next = lsq_pkg::ST_IDLE;
      end
    endcase

    if (advance)
    begin
      if (!last_step)
      begin
        pos_next = pos_inc;
        state_next = lsq_pkg::ST_LOAD;
      end
      else if (pass_done)
      begin
        state_next = lsq_pkg::ST_IDLE;
      end
      else
      begin
        pos_next = restart_pos; // R19
        pass_next = CW'(pass_reg + 16'h0001);
        state_next = lsq_pkg::ST_LOAD; // R12
      end
    end

    // register writes
    if (reject)
    begin
      err_set = 1'b1;
      err_val = lsq_pkg::ERR_CONFLICT; // R11
    end
    else if (wr_i)
    begin
      case (addr_i)
        lsq_pkg::A_ORDER_SEL: order_sel_next = wdata_i[0]; // R1
        lsq_pkg::A_DIR: dir_next = wdata_i[0];
        lsq_pkg::A_QSTART:
        begin
          if (wdata_i > 32'(lsq_pkg::LOC_LAST))
          begin
            err_set = 1'b1;
            err_val = lsq_pkg::ERR_RANGE;
          end
          else
          begin
            qstart_next = wdata_i[LW-1:0]; // R5
            rb_idx_next = '0;
          end
        end
        lsq_pkg::A_ORDER_DATA:
        begin
          if ((ord_cnt_reg >= lsq_pkg::ORD_FULL) ||
              (wdata_i > lsq_pkg::ORD_VAL_MAX))
          begin
            err_set = 1'b1;
            err_val = lsq_pkg::ERR_RANGE; // R20
          end
          else
          begin
            ord_we = 1'b1; // R7
            ord_cnt_next = LW'(ord_cnt_reg + 10'h001);
          end
        end
        lsq_pkg::A_ORDER_PTR: ord_cnt_next = '0;
        lsq_pkg::A_LEVEL_DATA:
        begin
          if (lvl_cnt_reg >= lsq_pkg::LIST_FULL)
          begin
            err_set = 1'b1;
            err_val = lsq_pkg::ERR_RANGE;
          end
          else
          begin
            lvl_we = 1'b1; // R18
            lvl_cnt_next = LW'(lvl_cnt_reg + 10'h001);
          end
        end
        lsq_pkg::A_DWELL_DATA:
        begin
          if (dw_cnt_reg >= lsq_pkg::LIST_FULL)
          begin
            err_set = 1'b1;
            err_val = lsq_pkg::ERR_RANGE;
          end
          else
          begin
            dw_we = 1'b1; // R14
            dw_cnt_next = LW'(dw_cnt_reg + 10'h001);
          end
        end
        lsq_pkg::A_CLEAR:
        begin
          lvl_cnt_next = '0; // R18
          dw_cnt_next = '0;
        end
        lsq_pkg::A_COUNT: count_next = wdata_i[CW-1:0];
        lsq_pkg::A_SKIP: skip_next = wdata_i[LW-1:0];
        lsq_pkg::A_MODE:
        begin
          if (wdata_i[1:0] == lsq_pkg::MODE_FIXED)
          begin
            if (running)
            begin
              state_next = lsq_pkg::ST_IDLE; // R13
            end
            pulse_armed_next = 1'b0;
          end
          else if (wdata_i[1:0] == lsq_pkg::MODE_PULSE)
          begin
            pulse_armed_next = 1'b1; // R16
          end
          else if ((wdata_i[1:0] == lsq_pkg::MODE_LIST) &&
                   (state_reg == lsq_pkg::ST_IDLE))
          begin
            if ((lvl_cnt_reg != dw_cnt_reg) || (n_steps == '0))
            begin
              err_set = 1'b1;
              err_val = lsq_pkg::ERR_CONFLICT; // R10
            end
            else
            begin
              pos_next = '0;
              pass_next = lsq_pkg::COUNT_RST;
              state_next = lsq_pkg::ST_LOAD;
            end
          end
        end
        lsq_pkg::A_PULSE_DUR: pulse_dur_next = wdata_i[DW-1:0];
        lsq_pkg::A_LEVEL:
        begin
          if (state_reg == lsq_pkg::ST_IDLE)
          begin
            if (pulse_armed_reg && (pulse_dur_reg != '0))
            begin
              restore_next = out_reg; // R16
              out_next = wdata_i[VW-1:0];
              timer_next = pulse_dur_reg;
              pulse_armed_next = 1'b0;
              state_next = lsq_pkg::ST_PULSE;
            end
            else
            begin
              level_next = wdata_i[VW-1:0];
              out_next = wdata_i[VW-1:0];
            end
          end
        end
        lsq_pkg::A_RANGE: range_next = wdata_i[3:0];
        default: ;
      endcase
    end

    // register reads
    if (rd_i && !reject)
    begin
      case (addr_i)
        lsq_pkg::A_ORDER_SEL: rdata_next = 32'(order_sel_reg); // R4
        lsq_pkg::A_DIR: rdata_next = 32'(dir_reg);
        lsq_pkg::A_QSTART: rdata_next = 32'(qstart_reg); // R6
        lsq_pkg::A_ORDER_DATA:
          rdata_next = (rb_ok && (rb_addr < ord_cnt_reg)) ?
                       32'(ord_rd_b) : '0; // R9
        lsq_pkg::A_ORDER_PTR: rdata_next = 32'(ord_cnt_reg);
        lsq_pkg::A_LEVEL_DATA:
          rdata_next = (rb_ok && (rb_addr < lvl_cnt_reg)) ?
                       32'($signed(lvl_rd_b)) : '0; // R6
        lsq_pkg::A_LEVEL_PTR: rdata_next = 32'(lvl_cnt_reg); // R18
        lsq_pkg::A_DWELL_DATA:
          rdata_next = (rb_ok && (rb_addr < dw_cnt_reg)) ?
                       32'(dw_rd_b) : '0; // R6
        lsq_pkg::A_DWELL_PTR: rdata_next = 32'(dw_cnt_reg); // R14
        lsq_pkg::A_COUNT: rdata_next = 32'(count_reg);
        lsq_pkg::A_SKIP: rdata_next = 32'(skip_reg);
        lsq_pkg::A_MODE: rdata_next = 32'({pulse_armed_reg, running});
        lsq_pkg::A_PULSE_DUR: rdata_next = 32'(pulse_dur_reg);
        lsq_pkg::A_LEVEL: rdata_next = 32'($signed(level_reg));
        lsq_pkg::A_RANGE: rdata_next = 32'(range_reg);
        lsq_pkg::A_ERROR: rdata_next = {15'h0000, err_flag_reg, err_code_reg};
        default: rdata_next = '0;
      endcase
      if (((addr_i == lsq_pkg::A_ORDER_DATA) ||
           (addr_i == lsq_pkg::A_LEVEL_DATA) ||
           (addr_i == lsq_pkg::A_DWELL_DATA)) && rb_ok)
      begin
        rb_idx_next = RW'(rb_idx_reg + 5'h01); // R9
      end
    end

    // error flag: a new error wins over the read that clears it
    err_flag_next = err_flag_reg;
    err_code_next = err_code_reg;
    if (rd_i && (addr_i == lsq_pkg::A_ERROR))
    begin
      err_flag_next = 1'b0;
    end
    if (err_set)
    begin
      err_flag_next = 1'b1;
      err_code_next = err_val;
    end

    // quarter scale keeps the sign
    level_o_next = (range_next == lsq_pkg::RANGE_QUARTER) ?
                   VW'($signed(out_next) >>> 2) : out_next; // R17
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= lsq_pkg::ST_IDLE;
      order_sel_reg <= 1'b0;
      dir_reg <= 1'b0;
      qstart_reg <= '0;
      rb_idx_reg <= '0;
      ord_cnt_reg <= '0;
      lvl_cnt_reg <= '0;
      dw_cnt_reg <= '0;
      count_reg <= lsq_pkg::COUNT_RST;
      skip_reg <= '0;
      pos_reg <= '0;
      pass_reg <= '0;
      timer_reg <= '0;
      pulse_dur_reg <= '0;
      pulse_armed_reg <= 1'b0;
      level_reg <= '0;
      out_reg <= '0;
      restore_reg <= '0;
      range_reg <= lsq_pkg::RANGE_FULL;
      err_code_reg <= lsq_pkg::ERR_NONE;
      err_flag_reg <= 1'b0;
      rdata_reg <= '0;
      level_o_reg <= '0;
      running_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      order_sel_reg <= order_sel_next;
      dir_reg <= dir_next;
      qstart_reg <= qstart_next;
      rb_idx_reg <= rb_idx_next;
      ord_cnt_reg <= ord_cnt_next;
      lvl_cnt_reg <= lvl_cnt_next;
      dw_cnt_reg <= dw_cnt_next;
      count_reg <= count_next;
      skip_reg <= skip_next;
      pos_reg <= pos_next;
      pass_reg <= pass_next;
      timer_reg <= timer_next;
      pulse_dur_reg <= pulse_dur_next;
      pulse_armed_reg <= pulse_armed_next;
      level_reg <= level_next;
      out_reg <= out_next;
      restore_reg <= restore_next;
      range_reg <= range_next;
      err_code_reg <= err_code_next;
      err_flag_reg <= err_flag_next;
      rdata_reg <= rdata_next;
      level_o_reg <= level_o_next;
      running_o <= (state_next == lsq_pkg::ST_LOAD) ||
                   (state_next == lsq_pkg::ST_HOLD);
    end
  end

  assign rdata_o = rdata_reg;
  assign level_o = level_o_reg;
  assign error_o = err_flag_reg;

endmodule

// File: verilog/lsq_table.sv
// one write port, two asynchronous read ports table
// assumes writes and reads in the same clock domain
`timescale 1ns/1ps
module lsq_table #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 1002,
  parameter int AW = 10
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [WIDTH-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_b_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // out-of-range addresses read as zero
  assign rdata_a_o = (int'(raddr_a_i) < DEPTH) ? mem[raddr_a_i] : '0;
  assign rdata_b_o = (int'(raddr_b_i) < DEPTH) ? mem[raddr_b_i] : '0;

endmodule
